// File: core/ring_net_pkg.sv
// constants and types shared by the ring and network status logic
package ring_net_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;

   ////////////////////////////////////////////////////////////////////////
   // times in milliseconds
   localparam int unsigned RING_PULSE_MS = 120;
   localparam int unsigned LED_ON_MS = 64;
   localparam int unsigned LED_OFF_UNREG_MS = 800;
   localparam int unsigned LED_OFF_REG_MS = 3000;
   localparam int unsigned LED_OFF_PACKET_MS = 300;

   ////////////////////////////////////////////////////////////////////////
   // derived cycle counts
   localparam int unsigned RING_PULSE_CYCLES = RING_PULSE_MS * CLK_PER_MS;
   localparam int unsigned LED_ON_CYCLES = LED_ON_MS * CLK_PER_MS;
   localparam int unsigned LED_OFF_UNREG_CYCLES = LED_OFF_UNREG_MS * CLK_PER_MS;
   localparam int unsigned LED_OFF_REG_CYCLES = LED_OFF_REG_MS * CLK_PER_MS;
   localparam int unsigned LED_OFF_PACKET_CYCLES = LED_OFF_PACKET_MS * CLK_PER_MS;

   ////////////////////////////////////////////////////////////////////////
   // counters and reset values
   localparam int COUNT_W = 32;
   localparam logic RING_IDLE_LEVEL = 1'b1;
   localparam logic LED_OFF_LEVEL = 1'b0;
   localparam logic RUNNING_RESET = 1'b0;

   typedef enum logic [1:0] {
      NET_UNREGISTERED = 2'b00,
      NET_REGISTERED = 2'b01,
      NET_PACKET_DATA = 2'b10
   } net_state_t;

   typedef enum logic [1:0] {
      RING_IDLE = 2'b00,
      RING_VOICE = 2'b01,
      RING_DATA = 2'b10
   } ring_state_t;

   typedef enum logic {
      BLINK_ON = 1'b0,
      BLINK_OFF = 1'b1
   } blink_phase_t;

   // call events from the modem core, one-cycle pulses except originating
   typedef struct packed {
      logic voice_incoming;
      logic data_incoming;
      logic established;
      logic hung_up;
      logic originating;
   } call_events_t;

endpackage

// File: core/led_blinker.sv
// network state led blink generator
`timescale 1ns/1ns
module led_blinker #(
   parameter int unsigned ON_CYCLES = 1,
   parameter int unsigned OFF_UNREG_CYCLES = 1,
   parameter int unsigned OFF_REG_CYCLES = 1,
   parameter int unsigned OFF_PACKET_CYCLES = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire ring_net_pkg::net_state_t net_state,
   output logic led
);
   import ring_net_pkg::*;

   blink_phase_t phase;
   net_state_t cycle_state;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] off_len;
   logic [COUNT_W-1:0] on_len;
   logic count_done;
   net_state_t next_cycle_state;

   assign on_len = COUNT_W'(ON_CYCLES);
   // off length follows the state sampled at the start of the cycle
   assign off_len = (cycle_state == NET_PACKET_DATA) ? COUNT_W'(OFF_PACKET_CYCLES) :
                    (cycle_state == NET_REGISTERED) ? COUNT_W'(OFF_REG_CYCLES) :
                    COUNT_W'(OFF_UNREG_CYCLES);
   assign count_done = (phase == BLINK_ON) ? (count >= on_len - 1'b1) : (count >= off_len - 1'b1);
   assign next_cycle_state = (net_state == NET_PACKET_DATA || net_state == NET_REGISTERED) ? net_state :
                             NET_UNREGISTERED;

   always_ff @(posedge clk) begin
      if (!rstn || !enable) begin
         phase <= BLINK_ON;
         count <= '0;
         cycle_state <= next_cycle_state;
         led <= LED_OFF_LEVEL;
      end else if (count_done) begin
         count <= '0;
         if (phase == BLINK_OFF) begin
            cycle_state <= next_cycle_state;
         end
         phase <= (phase == BLINK_ON) ? BLINK_OFF : BLINK_ON;
         led <= (phase == BLINK_OFF);
      end else begin
         count <= count + 1'b1;
         led <= (phase == BLINK_ON);
      end
   end
endmodule // led_blinker

// File: core/ring_net_status.sv
// ring indicator and network status led signalling of the modem module
`timescale 1ns/1ns
module ring_net_status #(
   parameter int unsigned RING_PULSE_CYCLES = ring_net_pkg::RING_PULSE_CYCLES,
   parameter int unsigned LED_ON_CYCLES = ring_net_pkg::LED_ON_CYCLES,
   parameter int unsigned LED_OFF_UNREG_CYCLES = ring_net_pkg::LED_OFF_UNREG_CYCLES,
   parameter int unsigned LED_OFF_REG_CYCLES = ring_net_pkg::LED_OFF_REG_CYCLES,
   parameter int unsigned LED_OFF_PACKET_CYCLES = ring_net_pkg::LED_OFF_PACKET_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic power_toggle_input,
   input wire logic module_reset_input,
   input wire ring_net_pkg::call_events_t call_events,
   input wire logic sms_received,
   input wire logic unsolicited_report,
   input wire ring_net_pkg::net_state_t net_state,
   output logic ring_indicator_n,
   output logic network_state_led,
   output logic module_running
);
   import ring_net_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and pulse detection

   logic [1:0] power_sync;
   logic [1:0] reset_sync;
   logic power_prev;
   logic reset_prev;
   wire power_pulse_end;
   wire reset_pulse_end;

   // a high pulse has just finished: it was high, now it is low
   function automatic logic pulse_ended(input logic was_high, input logic level);
      return was_high & ~level;
   endfunction

   // power toggle pin, two stages before anything reads it
   always_ff @(posedge clk) begin
      if (!rstn) begin
         power_sync <= 2'h0;
         power_prev <= 1'b0;
      end else begin
         power_sync <= {power_sync[0], power_toggle_input};
         power_prev <= power_sync[1];
      end
   end

   // module reset pin, same treatment
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reset_sync <= 2'h0;
         reset_prev <= 1'b0;
      end else begin
         reset_sync <= {reset_sync[0], module_reset_input};
         reset_prev <= reset_sync[1];
      end
   end

   // act on the falling edge so a single high pulse counts once
   assign power_pulse_end = pulse_ended(power_prev, power_sync[1]);
   assign reset_pulse_end = pulse_ended(reset_prev, reset_sync[1]);

   ////////////////////////////////////////////////////////////////////////
   // power state

   wire next_running;

   assign next_running = power_pulse_end ? ~module_running : module_running;

   // the reset pin leaves the power state alone
   always_ff @(posedge clk) begin
      if (!rstn) begin
         module_running <= RUNNING_RESET;
      end else begin
         module_running <= next_running;
      end
   end

   // events only count while the module runs and is not being reset
   wire active;
   assign active = module_running & ~reset_pulse_end;

   ////////////////////////////////////////////////////////////////////////
   // incoming call ringing

   ring_state_t ring_state;
   ring_state_t next_ring_state;
   wire call_ends;
   wire may_ring;
   wire voice_start;
   wire data_start;

   // either end of the call releases the line
   assign call_ends = call_events.established | call_events.hung_up;
   // a call placed by this module never pulls the line low
   assign may_ring = active & ~call_events.originating;
   // voice wins when both arrive together
   assign voice_start = may_ring & call_events.voice_incoming;
   assign data_start = may_ring & call_events.data_incoming & ~call_events.voice_incoming;

   always_comb begin
      next_ring_state = ring_state;
      case (ring_state)
         RING_IDLE: begin
            if (voice_start) begin
               next_ring_state = RING_VOICE;
            end else if (data_start) begin
               next_ring_state = RING_DATA;
            end
         end
         RING_VOICE: begin
            if (call_ends || !may_ring) begin
               next_ring_state = RING_IDLE;
            end
         end
         RING_DATA: begin
            if (call_ends || !may_ring) begin
               next_ring_state = RING_IDLE;
            end
         end
         default: begin
            next_ring_state = RING_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ring_state <= RING_IDLE;
      end else begin
         ring_state <= next_ring_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // message and report low pulse

   logic [COUNT_W-1:0] pulse_count;
   logic [COUNT_W-1:0] next_pulse_count;
   wire pulse_event;
   wire pulse_active;

   assign pulse_event = active & (sms_received | unsolicited_report);
   assign pulse_active = (pulse_count != '0);

   // set wins: an event in the last cycle of a pulse reloads it
   always_comb begin
      if (!active) begin
         next_pulse_count = '0;
      end else if (pulse_event) begin
         next_pulse_count = COUNT_W'(RING_PULSE_CYCLES);
      end else if (pulse_active) begin
         next_pulse_count = pulse_count - 1'b1;
      end else begin
         next_pulse_count = pulse_count;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pulse_count <= '0;
      end else begin
         pulse_count <= next_pulse_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ring indicator output

   wire next_ring_low;

   // built from next values so the pin moves on the event's own edge
   assign next_ring_low = (next_ring_state != RING_IDLE) | (next_pulse_count != '0);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ring_indicator_n <= RING_IDLE_LEVEL;
      end else begin
         ring_indicator_n <= ~next_ring_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // network status led

   // blinker restarts from dark whenever the module stops or is reset
   wire led_enable;
   assign led_enable = active;

   led_blinker #(
      .ON_CYCLES(LED_ON_CYCLES),
      .OFF_UNREG_CYCLES(LED_OFF_UNREG_CYCLES),
      .OFF_REG_CYCLES(LED_OFF_REG_CYCLES),
      .OFF_PACKET_CYCLES(LED_OFF_PACKET_CYCLES)
   ) u_led_blinker (
      .clk(clk),
      .rstn(rstn),
      .enable(led_enable),
      .net_state(net_state),
      .led(network_state_led)
   );

endmodule // ring_net_status

// File: tb/ring_net_checker.sv
// port assertions for the ring and network status block
`timescale 1ns/1ns
module ring_net_checker #(
   parameter int unsigned RING_PULSE_CYCLES = 2,
   parameter int unsigned LED_ON_CYCLES = 2,
   parameter int unsigned LED_OFF_UNREG_CYCLES = 2,
   parameter int unsigned LED_OFF_REG_CYCLES = 2,
   parameter int unsigned LED_OFF_PACKET_CYCLES = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic power_toggle_input,
   input wire logic module_reset_input,
   input wire ring_net_pkg::call_events_t call_events,
   input wire logic sms_received,
   input wire logic unsolicited_report,
   input wire ring_net_pkg::net_state_t net_state,
   input wire logic ring_indicator_n,
   input wire logic network_state_led,
   input wire logic module_running
);
   import ring_net_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [31:0] left;
   logic [31:0] run_len;
   logic [31:0] off_exp;
   logic [2:0] since_rst;
   logic armed;
   wire ev = module_running && (sms_received || unsolicited_report);
   wire [31:0] off_now = net_state == NET_REGISTERED ? LED_OFF_REG_CYCLES
      : net_state == NET_PACKET_DATA ? LED_OFF_PACKET_CYCLES : LED_OFF_UNREG_CYCLES;
   // lengths judged only after a clean fall; a reset pin pulse restarts the blinker a few cycles late
   always_ff @(posedge clk) begin
      left <= (!rstn || !module_running) ? '0 : ev ? RING_PULSE_CYCLES : left - 32'(left != '0);
      run_len <= $changed(network_state_led) ? 32'h1 : run_len + 32'h1;
      since_rst <= (!rstn || module_reset_input) ? 3'h0 : since_rst + 3'(since_rst != 3'h7);
      armed <= rstn && module_running && !module_reset_input && since_rst == 3'h7
         && (armed || $fell(network_state_led));
      if ($rose(network_state_led)) off_exp <= off_now;
   end
   sequence s_call;
      module_running && !call_events.originating && (call_events.voice_incoming || call_events.data_incoming);
   endsequence
   sequence s_last;
      module_running && left == 32'h1 && !ev;
   endsequence
   sequence s_off;
      !module_running ##1 !module_running;
   endsequence
   a_pulse_low: assert property (module_running && left != '0 |-> !ring_indicator_n)
      else $error("ring high in pulse");
   a_pulse_end: assert property (s_last |=> ring_indicator_n)
      else $error("pulse too long");
   a_call_low: assert property (s_call |=> !ring_indicator_n)
      else $error("no ring on call");
   a_idle_high: assert property (s_off |-> ring_indicator_n)
      else $error("ring low when off");
   a_led_dark: assert property (s_off |-> !network_state_led)
      else $error("led lit when off");
   a_led_on: assert property ($fell(network_state_led) && armed |-> run_len == LED_ON_CYCLES)
      else $error("led on length");
   a_led_off: assert property ($rose(network_state_led) && armed |-> run_len == off_exp)
      else $error("led off length");
   a_power_turn: assert property ($fell(power_toggle_input) |-> ##[2:5] $changed(module_running))
      else $error("power pulse ignored");
endmodule // ring_net_checker

// File: tb/host_pins.sv
// host side model driving the power and reset pins
`timescale 1ns/1ns
module host_pins (
   input wire logic clk,
   output logic power_toggle_input,
   output logic module_reset_input
);
   initial power_toggle_input = 1'h0;
   initial module_reset_input = 1'h0;
   // single high pulse, width shortened for simulation
   // no card access is modelled, so none can come before ready
   task automatic pulse(input bit rst);
      @(posedge clk);
      #1;
      if (rst) module_reset_input = 1'h1;
      else power_toggle_input = 1'h1;
      repeat (5) @(posedge clk);
      #1;
      {power_toggle_input, module_reset_input} = 2'h0;
   endtask
endmodule // host_pins

// File: tb/tb.sv
// self-checking bench for the ring and network status block
`timescale 1ns/1ns
module tb;
   import ring_net_pkg::*;
   logic clk, rstn, sms, rpt, ri, led, run, pwr, mrst;
   call_events_t ce;
   net_state_t ns;
   int miscompares, tests_run, n;
   net_state_t sts[3] = '{NET_PACKET_DATA, NET_REGISTERED, NET_UNREGISTERED};
   int offs[3] = '{6, 30, 10};
   ring_net_status #(.RING_PULSE_CYCLES(20), .LED_ON_CYCLES(4), .LED_OFF_UNREG_CYCLES(10),
      .LED_OFF_REG_CYCLES(30), .LED_OFF_PACKET_CYCLES(6)) i_dut (.clk(clk), .rstn(rstn),
      .power_toggle_input(pwr), .module_reset_input(mrst), .call_events(ce), .sms_received(sms),
      .unsolicited_report(rpt), .net_state(ns), .ring_indicator_n(ri), .network_state_led(led),
      .module_running(run));
   host_pins i_host (.clk(clk), .power_toggle_input(pwr), .module_reset_input(mrst));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic fire(input logic [5:0] v);
      ce.voice_incoming = v[5];
      ce.data_incoming = v[4];
      ce.established = v[3];
      ce.hung_up = v[2];
      sms = v[1];
      rpt = v[0];
      step(1);
      ce.voice_incoming = 1'h0;
      ce.data_incoming = 1'h0;
      ce.established = 1'h0;
      ce.hung_up = 1'h0;
      sms = 1'h0;
      rpt = 1'h0;
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? ri : s == 1 ? led : run;
   endfunction
   // cycles the picked output holds a level, bounded
   task automatic len(input int s, input logic lvl, output int k);
      k = 0;
      while (pick(s) === lvl && k < 300) begin
         step(1);
         k++;
      end
   endtask
   task automatic t_on;
      i_host.pulse(0);
      len(2, 1'h0, n);
      chk("power on", run, 1'h1);
      chk("ring idle", ri, 1'h1);
      $display("power on test done");
   endtask
   task automatic t_ring;
      for (int i = 0; i < 2; i++) begin
         fire(i ? 6'h01 : 6'h02);
         len(0, 1'h0, n);
         chk("pulse", n, 20);
      end
      fire(6'h02);
      step(9);
      fire(6'h01);
      len(0, 1'h0, n);
      chk("restart", n, 20);
      for (int i = 0; i < 4; i++) begin
         fire(i[1] ? 6'h10 : 6'h20);
         step(3);
         chk("ringing", ri, 1'h0);
         fire(i[0] ? 6'h04 : 6'h08);
         chk("answered", ri, 1'h1);
         step(1);
      end
      ce.originating = 1'h1;
      step(1);
      fire(6'h20);
      chk("caller", ri, 1'h1);
      step(1);
      ce.originating = 1'h0;
      $display("ring test done");
   endtask
   task automatic t_led;
      // align to the first cycle of an on phase
      len(1, 1'h1, n);
      len(1, 1'h0, n);
      for (int i = 0; i < 3; i++) begin
         len(1, 1'h1, n);
         chk("led on", n, 4);
         ns = sts[i];
         len(1, 1'h0, n);
         chk("old off", n, i ? offs[i-1] : 10);
         len(1, 1'h1, n);
         len(1, 1'h0, n);
         chk("new off", n, offs[i]);
      end
      i_host.pulse(1);
      step(6);
      chk("running", run, 1'h1);
      $display("led test done");
   endtask
   task automatic t_off;
      i_host.pulse(0);
      len(2, 1'h1, n);
      fire(6'h02);
      len(1, 1'h0, n);
      chk("led dark", n, 300);
      chk("ring off", ri, 1'h1);
      $display("off test done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      rstn = 1'h0;
      sms = 1'h0;
      rpt = 1'h0;
      ce = '0;
      ns = NET_UNREGISTERED;
      step(3);
      rstn = 1'h1;
      t_on;
      t_ring;
      t_led;
      t_off;
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
endmodule // tb
bind ring_net_status ring_net_checker #(
   .RING_PULSE_CYCLES(RING_PULSE_CYCLES),
   .LED_ON_CYCLES(LED_ON_CYCLES),
   .LED_OFF_UNREG_CYCLES(LED_OFF_UNREG_CYCLES),
   .LED_OFF_REG_CYCLES(LED_OFF_REG_CYCLES),
   .LED_OFF_PACKET_CYCLES(LED_OFF_PACKET_CYCLES)
) i_chk (
   .clk(clk),
   .rstn(rstn),
   .power_toggle_input(power_toggle_input),
   .module_reset_input(module_reset_input),
   .call_events(call_events),
   .sms_received(sms_received),
   .unsolicited_report(unsolicited_report),
   .net_state(net_state),
   .ring_indicator_n(ring_indicator_n),
   .network_state_led(network_state_led),
   .module_running(module_running)
);
